// file: src/adcc_pkg.sv
/*
 * Shared definitions of the converter control block: register map,
 * field layouts, reset values, mode and clock encodings, state codes
 * and the packed carriers used on the block's ports.
 * Assumes a 32-bit APB master and byte addresses on paddr.
 */
package adcc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register byte offsets, one aligned word each
    localparam logic [7:0] ADCC_OFS_SC1 = 8'h00;
    localparam logic [7:0] ADCC_OFS_SC2 = 8'h04;
    localparam logic [7:0] ADCC_OFS_RES_HIGH = 8'h08;
    localparam logic [7:0] ADCC_OFS_RES_LOW = 8'h0C;
    localparam logic [7:0] ADCC_OFS_CV_HIGH = 8'h10;
    localparam logic [7:0] ADCC_OFS_CV_LOW = 8'h14;
    localparam logic [7:0] ADCC_OFS_CFG = 8'h18;
    localparam logic [7:0] ADCC_OFS_PIN_MID = 8'h20;
    localparam logic [7:0] ADCC_OFS_PIN_HIGH = 8'h24;

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ADCC_SC1_FLAG = 7;
    localparam int ADCC_SC1_IRQ_EN = 6;
    localparam int ADCC_SC1_CONT = 5;
    localparam int ADCC_SC2_BUSY = 7;
    localparam int ADCC_SC2_HW_SEL = 6;
    localparam int ADCC_SC2_CMP_EN = 5;
    localparam int ADCC_SC2_CMP_GT = 4;
    localparam int ADCC_CFG_DIV_LSB = 5;
    localparam int ADCC_CFG_LSMP = 4;
    localparam int ADCC_CFG_MODE_LSB = 2;

    ////////////////////////////////////////////////////////////////////
    // Reset values and encodings
    localparam logic [4:0] ADCC_CHAN_OFF = 5'h1F;
    localparam logic [4:0] ADCC_CHAN_RESET = 5'h1F;
    localparam logic [7:0] ADCC_PIN_RESET = 8'h00;
    localparam logic [1:0] ADCC_MODE_8 = 2'b00;
    localparam logic [1:0] ADCC_MODE_10 = 2'b10;
    localparam logic [1:0] ADCC_CLK_BUS = 2'b00;
    localparam logic [1:0] ADCC_CLK_BUS_HALF = 2'b01;
    localparam logic [1:0] ADCC_CLK_ALT = 2'b10;
    localparam logic [1:0] ADCC_CLK_ASYNC = 2'b11;
    localparam logic [3:0] ADCC_MSB_IDX = 4'd10;
    localparam logic [3:0] ADCC_LSB_IDX_10 = 4'd0;
    localparam logic [3:0] ADCC_LSB_IDX_8 = 4'd2;
    localparam logic [1:0] ADCC_SETTLE_CYC = 2'd3;

    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONVERT = 2'b10,
        ADCC_DONE = 2'b11
    } adcc_state_e;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } adcc_apb_req_t;

    // Pad controls for channels 8 to 23, bit 0 is channel 8
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe_n;
        logic [15:0] pullup_en;
        logic [15:0] in_buf_en;
    } adcc_pad_t;

endpackage

// file: src/adcc_ctrl.sv
/*
 * Conversion control of a successive approximation converter: APB
 * registers, pin control of channels 8 to 23, converter clock select
 * and divide, software, hardware and continuous starts, rounding,
 * compare and completion flag.
 * Assumes the analog comparator and trigger arrive asynchronously and
 * that the analog array follows sar_code_o and sample_o.
 */
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps

// Contract
// - Mid pin register bit n disables port control of channel 8+n.
// - High pin register bit n disables port control of channel 16+n.
// - Disabled pin: output driver released and pullup off.
// - Disabled pin: input buffer off, port read returns zero.
// - Converter off in reset and while channel select is all ones.
// - After completion with no new start, converter idles at lowest power.
// - Ten-bit mode: 11-bit raw value rounded to 10, both result registers.
// - Eight-bit mode: 9-bit raw value rounded to 8, low register only.
// - After result write set complete flag; interrupt if enabled.
// - Compare enable checks every result in every mode.
// - Four clock sources selectable, bus clock after reset.
// - Clock select codes: bus, bus half, alternate, internal async.
// - Selected source divided by 1, 2, 4 or 8.
// - Divide codes 00,01,10,11 give 1,2,4,8.
// - Bus half plus divider gives division up to 16.
// - Internal async clock keeps running in wait and stop3.
// - Hardware select set: trigger rising edge starts a conversion.
// - Trigger edge during a conversion is ignored.
// - Continuous hardware series acts only on its first edge.
// - Mode code 00 is 8-bit, 10 is 10-bit, others reserved.
// - Software mode: first status write starts unless channel all ones.
// - Continuous mode restarts right after result transfer.
// - Continuous software series starts on status write, runs until abort.
// - Continuous hardware series starts on trigger, runs until abort.
module adcc_ctrl #(
    parameter int SHORT_SAMPLE = 3,
    parameter int LONG_SAMPLE = 23,
    parameter int ASYNC_DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adcc_pkg::adcc_apb_req_t apb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire logic hw_trigger_input_i,
    input wire logic alternate_clock_i,
    input wire logic comp_i,
    input wire logic stop_mode_i,
    output logic [10:0] sar_code_o,
    output logic sample_o,
    output logic [4:0] channel_o,
    output logic analog_enable_o,
    output logic internal_async_clock_en_o,
    output logic converter_clock_o,
    output logic irq_o,
    input wire logic [15:0] port_out_i,
    input wire logic [15:0] port_drive_i,
    input wire logic [15:0] port_pullup_i,
    input wire logic [15:0] pad_in_i,
    output adcc_pkg::adcc_pad_t pad_o,
    output logic [15:0] port_read_o
);
    import adcc_pkg::*;

    typedef struct packed {
        adcc_state_e st;
        logic [4:0] chan;
        logic cont;
        logic irq_en;
        logic flag;
        logic hw_sel;
        logic cmp_en;
        logic cmp_gt;
        logic [1:0] div;
        logic lsmp;
        logic [1:0] mode;
        logic [1:0] clk_sel;
        logic [7:0] pin_mid;
        logic [7:0] pin_high;
        logic [1:0] cv_hi;
        logic [7:0] cv_lo;
        logic [1:0] res_hi;
        logic [7:0] res_lo;
        logic [10:0] code;
        logic [3:0] bit_idx;
        logic [5:0] smp_cnt;
        logic tick_pend;
        logic [1:0] settle;
        logic half;
        logic [2:0] div_cnt;
        logic [3:0] async_cnt;
        logic series;
        logic converter_clock;
        logic trig_s1;
        logic trig_s2;
        logic trig_d;
        logic alt_s1;
        logic alt_s2;
        logic alt_d;
        logic comp_s1;
        logic comp_s2;
        logic [15:0] pad_s1;
        logic [15:0] pad_s2;
        logic [31:0] rdata;
    } adcc_regs_t;

    adcc_regs_t s;
    adcc_regs_t next_s;

    ////////////////////////////////////////////////////////////////////
    // Address decode, used only for the error answer; read data decodes on its own
    function automatic logic adcc_mapped(input logic [7:0] a);
        case (a)
            ADCC_OFS_SC1, ADCC_OFS_SC2, ADCC_OFS_RES_HIGH,
            ADCC_OFS_RES_LOW, ADCC_OFS_CV_HIGH, ADCC_OFS_CV_LOW,
            ADCC_OFS_CFG, ADCC_OFS_PIN_MID,
            ADCC_OFS_PIN_HIGH: adcc_mapped = 1'b1;
            default: adcc_mapped = 1'b0;
        endcase
    endfunction

    // Round the raw value half up, saturating at full scale
    function automatic logic [9:0] adcc_round(input logic [10:0] raw,
                                              input logic ten);
        logic [10:0] sum;
        sum = 11'h000;
        if (ten) begin
            sum = {1'b0, raw[10:1]} + {10'h000, raw[0]};
            adcc_round = sum[10] ? 10'h3FF : sum[9:0];
        end else begin
            sum = {3'b000, raw[8:1]} + {10'h000, raw[0]};
            adcc_round = sum[8] ? 10'h0FF : {2'b00, sum[7:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic wr_acc;
    logic rd_acc;
    logic wr_sc1;
    logic wr_mode;
    logic ten;
    logic chan_off;
    logic src_tick;
    logic converter_clock_tick;
    logic trig_rise;
    logic sw_start;
    logic hw_start;
    logic abort;
    logic [2:0] div_lim;
    logic [5:0] smp_lim;
    logic [9:0] rounded;
    logic [9:0] cv;
    logic [9:0] diff;
    logic cmp_ok;
    logic [15:0] pin_dis;

    // Bus strobes: writes and read side effects act in the access phase
    assign wr_acc = apb_i.psel & apb_i.penable & apb_i.pwrite;
    assign rd_acc = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
    assign wr_sc1 = wr_acc & (apb_i.paddr == ADCC_OFS_SC1);
    // Writes to SC2, CFG and the compare values change the operating mode mid-flight
    assign wr_mode = wr_acc & ((apb_i.paddr == ADCC_OFS_SC2)
        | (apb_i.paddr == ADCC_OFS_CFG)
        | (apb_i.paddr == ADCC_OFS_CV_HIGH)
        | (apb_i.paddr == ADCC_OFS_CV_LOW));
    assign ten = (s.mode == ADCC_MODE_10);
    assign chan_off = (s.chan == ADCC_CHAN_OFF);
    assign trig_rise = s.trig_s2 & ~s.trig_d;
    assign pin_dis = {s.pin_high, s.pin_mid};

    // async keeps ticking in stop
    // Only the internal clock survives stop; the others stand still
    always_comb begin
        case (s.clk_sel)
            ADCC_CLK_BUS: src_tick = ~stop_mode_i;
            ADCC_CLK_BUS_HALF: src_tick = ~stop_mode_i & s.half;
            ADCC_CLK_ALT: src_tick = ~stop_mode_i & s.alt_s2 & ~s.alt_d;
            ADCC_CLK_ASYNC: src_tick = (s.async_cnt == 4'(ASYNC_DIV - 1));
            default: src_tick = 1'b0;
        endcase
    end

    assign div_lim = 3'((4'd1 << s.div) - 4'd1);
    assign converter_clock_tick = src_tick & (s.div_cnt == div_lim);
    assign smp_lim = s.lsmp ? 6'(LONG_SAMPLE) : 6'(SHORT_SAMPLE);

    assign sw_start = wr_sc1 & ~s.hw_sel
        & (apb_i.pwdata[4:0] != ADCC_CHAN_OFF);
    assign hw_start = s.hw_sel & trig_rise & (s.st == ADCC_IDLE)
        & ~s.series & ~chan_off;
    // Stop without the internal clock leaves no clock to finish on
    assign abort = wr_sc1 | wr_mode
        | (stop_mode_i & (s.clk_sel != ADCC_CLK_ASYNC));

    assign rounded = adcc_round(ten ? s.code : {2'b00, s.code[10:2]}, ten);
    assign cv = ten ? {s.cv_hi, s.cv_lo} : {2'b00, s.cv_lo};
    assign diff = rounded - cv;
    assign cmp_ok = ~s.cmp_en | (s.cmp_gt ? (rounded >= cv) : (rounded < cv));

    ////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        next_s = s;
        // Synchronisers: the first stage feeds only the second
        next_s.trig_s1 = hw_trigger_input_i;
        next_s.trig_s2 = s.trig_s1;
        next_s.trig_d = s.trig_s2;
        next_s.alt_s1 = alternate_clock_i;
        next_s.alt_s2 = s.alt_s1;
        next_s.alt_d = s.alt_s2;
        next_s.comp_s1 = comp_i;
        next_s.comp_s2 = s.comp_s1;
        next_s.pad_s1 = pad_in_i;
        next_s.pad_s2 = s.pad_s1;
        next_s.half = ~s.half;
        next_s.converter_clock = 1'b0;
        // Internal oscillator only runs while a conversion needs it
        if (s.clk_sel == ADCC_CLK_ASYNC && s.st != ADCC_IDLE) begin
            next_s.async_cnt = src_tick ? 4'h0 : s.async_cnt + 4'h1;
        end else begin
            next_s.async_cnt = 4'h0;
        end

        if (s.st == ADCC_IDLE) begin
            next_s.div_cnt = 3'h0;
        end else if (src_tick) begin
            next_s.div_cnt = converter_clock_tick ? 3'h0 : s.div_cnt + 3'h1;
            next_s.converter_clock = converter_clock_tick;
        end

        // Read data is captured in the setup phase so it leaves a flop
        if (apb_i.psel && !apb_i.penable) begin
            case (apb_i.paddr)
                ADCC_OFS_SC1: next_s.rdata = {24'h0, s.flag, s.irq_en,
                    s.cont, s.chan};
                ADCC_OFS_SC2: next_s.rdata = {24'h0, s.st != ADCC_IDLE,
                    s.hw_sel, s.cmp_en, s.cmp_gt, 4'h0};
                ADCC_OFS_RES_HIGH: next_s.rdata = {30'h0, s.res_hi};
                ADCC_OFS_RES_LOW: next_s.rdata = {24'h0, s.res_lo};
                ADCC_OFS_CV_HIGH: next_s.rdata = {30'h0, s.cv_hi};
                ADCC_OFS_CV_LOW: next_s.rdata = {24'h0, s.cv_lo};
                ADCC_OFS_CFG: next_s.rdata = {25'h0, s.div, s.lsmp,
                    s.mode, s.clk_sel};
                ADCC_OFS_PIN_MID: next_s.rdata = {24'h0, s.pin_mid};
                ADCC_OFS_PIN_HIGH: next_s.rdata = {24'h0, s.pin_high};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (wr_acc) begin
            case (apb_i.paddr)
                ADCC_OFS_SC1: begin
                    next_s.chan = apb_i.pwdata[4:0];
                    next_s.cont = apb_i.pwdata[ADCC_SC1_CONT];
                    next_s.irq_en = apb_i.pwdata[ADCC_SC1_IRQ_EN];
                end
                ADCC_OFS_SC2: begin
                    next_s.hw_sel = apb_i.pwdata[ADCC_SC2_HW_SEL];
                    next_s.cmp_en = apb_i.pwdata[ADCC_SC2_CMP_EN];
                    next_s.cmp_gt = apb_i.pwdata[ADCC_SC2_CMP_GT];
                end
                ADCC_OFS_CV_HIGH: next_s.cv_hi = apb_i.pwdata[1:0];
                ADCC_OFS_CV_LOW: next_s.cv_lo = apb_i.pwdata[7:0];
                ADCC_OFS_CFG: begin
                    next_s.div = apb_i.pwdata[ADCC_CFG_DIV_LSB +: 2];
                    next_s.lsmp = apb_i.pwdata[ADCC_CFG_LSMP];
                    next_s.mode = apb_i.pwdata[ADCC_CFG_MODE_LSB +: 2];
                    next_s.clk_sel = apb_i.pwdata[1:0];
                end
                ADCC_OFS_PIN_MID: next_s.pin_mid = apb_i.pwdata[7:0];
                ADCC_OFS_PIN_HIGH: next_s.pin_high = apb_i.pwdata[7:0];
                default: next_s.pin_mid = s.pin_mid;
            endcase
        end

        // Flag clears on a status write or a low result read
        if (wr_sc1 || (rd_acc && apb_i.paddr == ADCC_OFS_RES_LOW)) begin
            next_s.flag = 1'b0;
        end

        // SAR step waits for the synchronised comparator to settle
        if (s.converter_clock) begin
            next_s.tick_pend = 1'b1;
        end
        if (s.settle != ADCC_SETTLE_CYC) begin
            next_s.settle = s.settle + 2'd1;
        end

        // Sequencer
        case (s.st)
            ADCC_IDLE: begin
                next_s.series = 1'b0;
            end
            ADCC_SAMPLE: begin
                if (s.converter_clock) begin
                    next_s.smp_cnt = s.smp_cnt + 6'd1;
                    if (s.smp_cnt == smp_lim - 6'd1) begin
                        next_s.st = ADCC_CONVERT;
                        next_s.code = 11'h400;
                        next_s.bit_idx = ADCC_MSB_IDX;
                        next_s.tick_pend = 1'b0;
                        next_s.settle = 2'd0;
                    end
                end
            end
            ADCC_CONVERT: begin
                if ((s.tick_pend || s.converter_clock)
                    && s.settle == ADCC_SETTLE_CYC) begin
                    next_s.tick_pend = 1'b0;
                    next_s.settle = 2'd0;
                    // Keep the trial bit if the input sits above it
                    next_s.code[s.bit_idx] = s.comp_s2;
                    if (s.bit_idx == (ten ? ADCC_LSB_IDX_10
                                          : ADCC_LSB_IDX_8)) begin
                        next_s.st = ADCC_DONE;
                    end else begin
                        next_s.bit_idx = s.bit_idx - 4'd1;
                        next_s.code[s.bit_idx - 4'd1] = 1'b1;
                    end
                end
            end
            ADCC_DONE: begin
                if (cmp_ok) begin
                    if (ten) begin
                        next_s.res_hi = s.cmp_en ? diff[9:8] : rounded[9:8];
                    end
                    next_s.res_lo = s.cmp_en ? diff[7:0] : rounded[7:0];
                    next_s.flag = 1'b1;
                end
                next_s.st = s.cont ? ADCC_SAMPLE : ADCC_IDLE;
                next_s.smp_cnt = 6'd0;
            end
            default: next_s.st = ADCC_IDLE;
        endcase

        // Aborts and starts override the sequencer
        if (abort) begin
            next_s.st = ADCC_IDLE;
            next_s.series = 1'b0;
        end
        if (sw_start || hw_start) begin
            next_s.st = ADCC_SAMPLE;
            next_s.smp_cnt = 6'd0;
            next_s.series = next_s.cont;
        end
        if (next_s.chan == ADCC_CHAN_OFF) begin
            next_s.st = ADCC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    // off in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.st <= ADCC_IDLE;
            s.chan <= ADCC_CHAN_RESET;
            s.clk_sel <= ADCC_CLK_BUS;
            s.mode <= ADCC_MODE_8;
            s.pin_mid <= ADCC_PIN_RESET;
            s.pin_high <= ADCC_PIN_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB answer: no wait states, unmapped addresses flag an error
    assign pready_o = apb_i.psel & apb_i.penable;
    assign pslverr_o = pready_o & ~adcc_mapped(apb_i.paddr);
    assign prdata_o = s.rdata;

    // Analog side controls
    assign sar_code_o = s.code;
    assign sample_o = (s.st == ADCC_SAMPLE);
    assign channel_o = s.chan;
    assign analog_enable_o = (s.st != ADCC_IDLE);
    assign internal_async_clock_en_o = (s.clk_sel == ADCC_CLK_ASYNC)
        & (s.st != ADCC_IDLE);
    assign converter_clock_o = s.converter_clock;
    assign irq_o = s.flag & s.irq_en;

    assign pad_o.out = port_out_i & ~pin_dis;
    assign pad_o.oe_n = pin_dis | ~port_drive_i;
    assign pad_o.pullup_en = port_pullup_i & ~pin_dis;
    assign pad_o.in_buf_en = ~pin_dis;
    assign port_read_o = s.pad_s2 & ~pin_dis;

endmodule

// file: test/adcc_ctrl_assertions.sv
/*
 * Port checker of the converter control block, bound from the bench.
 * Assumes zero-wait APB and a flag cleared by status writes or low
 * result reads.
 */
`timescale 1ns/100ps
module adcc_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adcc_pkg::adcc_apb_req_t apb_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic sample_o,
    input wire logic analog_enable_o,
    input wire logic irq_o,
    input wire logic [4:0] channel_o,
    input wire adcc_pkg::adcc_pad_t pad_o,
    input wire logic [15:0] port_read_o
);
    import adcc_pkg::*;
    logic acc, wr_en, clr, hw_sel;
    logic [15:0] dis;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // Access phase, writes, flag clearing accesses, disabled pins
    assign acc = apb_i.psel && apb_i.penable;
    assign wr_en = acc && apb_i.pwrite;
    assign clr = acc && (apb_i.paddr == ADCC_OFS_SC1 ||
        apb_i.paddr == ADCC_OFS_RES_LOW);
    assign dis = ~pad_o.in_buf_en;
    // Trigger select mirror, so hardware mode is not taken as a start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hw_sel <= 1'h0;
        end else if (wr_en && apb_i.paddr == ADCC_OFS_SC2) begin
            hw_sel <= apb_i.pwdata[ADCC_SC2_HW_SEL];
        end
    end
    sequence sc1_wr;
        wr_en && apb_i.paddr == ADCC_OFS_SC1;
    endsequence
    sequence sw_go;
        sc1_wr ##0 (!hw_sel && apb_i.pwdata[4:0] != ADCC_CHAN_OFF);
    endsequence
    ////////////////////////////////////////////////////////////////
    ready_in_access_a: assert property (acc |-> pready_o)
        else $error("pready missing in access phase");
    error_in_access_a: assert property (pslverr_o |-> acc)
        else $error("pslverr outside access phase");
    pin_hiz_a: assert property ((dis & ~pad_o.oe_n) == 16'h0000)
        else $error("disabled pin still driven");
    pin_pullup_a: assert property ((dis & pad_o.pullup_en) == 16'h0000)
        else $error("disabled pin keeps pullup");
    pin_read_a: assert property ((dis & port_read_o) == 16'h0000)
        else $error("disabled pin reads nonzero");
    chan_off_a: assert property (
        channel_o == ADCC_CHAN_OFF |-> !analog_enable_o)
        else $error("converter on with channel off");
    reset_off_a: assert property ($fell(rst_i) |-> !analog_enable_o)
        else $error("converter on after reset");
    sw_start_a: assert property (sw_go |=> sample_o)
        else $error("status write did not start sampling");
    flag_hold_a: assert property (irq_o && !clr |=> irq_o)
        else $error("completion request dropped");
endmodule

// file: test/tb_adc_conversion_control.sv
/*
 * Self-checking bench of the converter control block, driven over APB.
 * Assumes the checker file is compiled before this one.
 */
`timescale 1ns/100ps
module tb_adc_conversion_control;
    import adcc_pkg::*;
    logic clk_i, rst_i, hw, alt, comp, stop, pready, perr, se;
    logic smp, aen, aclk, ck, irq;
    logic [4:0] chan;
    logic [10:0] sar, vin;
    logic [15:0] drv, prd;
    logic [31:0] prdata, q;
    logic [2:0] ac;
    adcc_apb_req_t apb;
    adcc_pad_t pad;
    int num_errors, n_tests;
    ////////////////////////////////////////////////////////////////
    // Bus clock
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    // Comparator half a step above vin; alternate clock of six cycles
    always @(posedge clk_i) begin
        comp <= {vin, 1'h1} > {sar, 1'h0};
        ac <= (rst_i || ac == 3'h5) ? 3'h0 : ac + 3'h1;
        alt <= ac < 3'h3;
    end
    adcc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb),
        .pready_o(pready), .pslverr_o(perr), .prdata_o(prdata),
        .hw_trigger_input_i(hw), .alternate_clock_i(alt), .comp_i(comp),
        .stop_mode_i(stop), .sar_code_o(sar), .sample_o(smp),
        .channel_o(chan), .analog_enable_o(aen),
        .internal_async_clock_en_o(aclk), .converter_clock_o(ck),
        .irq_o(irq), .port_out_i(drv), .port_drive_i(drv),
        .port_pullup_i(drv), .pad_in_i(drv), .pad_o(pad),
        .port_read_o(prd));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    // One transfer, then an idle cycle so calls never collide
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        apb <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk_i);
        apb.penable <= 1'h1;
        @(posedge clk_i);
        while (pready !== 1'h1) @(posedge clk_i);
        q = prdata;
        se = perr;
        apb.psel <= 1'h0;
        apb.penable <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 4000 && s !== 1'h1; i++) @(posedge clk_i);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Single conversion with flag, results and return to idle
    task automatic conv(input logic [7:0] cfg, input logic [10:0] v,
        input logic [7:0] h, l);
        bus(1'h1, ADCC_OFS_CFG, cfg);
        vin <= v;
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0043);
        wait_hi(irq);
        bus(1'h0, ADCC_OFS_SC1, 32'h0);
        chk("flag", q[ADCC_SC1_FLAG], 1'h1);
        bus(1'h0, ADCC_OFS_RES_HIGH, 32'h0);
        chk("res_high", q, h);
        bus(1'h0, ADCC_OFS_RES_LOW, 32'h0);
        chk("res_low", q, l);
        chk("idle", aen, 1'h0);
    endtask
    // Gap between converter ticks for one clock setting
    task automatic period(input logic [7:0] cfg, input int e);
        int n;
        bus(1'h1, ADCC_OFS_CFG, cfg);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0003);
        wait_hi(ck);
        @(posedge clk_i);
        for (n = 1; n < 99 && ck !== 1'h1; n++) @(posedge clk_i);
        chk("tick_gap", n, e);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_001F);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'h0, ADCC_OFS_PIN_MID, 32'h0);
        chk("pin_mid", q, 32'h0);
        bus(1'h0, ADCC_OFS_PIN_HIGH, 32'h0);
        chk("pin_high", q, 32'h0);
        bus(1'h0, ADCC_OFS_CFG, 32'h0);
        chk("cfg", q, 32'h0);
        bus(1'h0, 8'h1C, 32'h0);
        chk("unmapped", se, 1'h1);
        chk("off", aen, 1'h0);
    endtask
    task automatic t_pins();
        bus(1'h1, ADCC_OFS_PIN_MID, 32'h0000_00A5);
        bus(1'h1, ADCC_OFS_PIN_HIGH, 32'h0000_003C);
        bus(1'h0, ADCC_OFS_PIN_MID, 32'h0);
        chk("mid", q, 32'h0000_00A5);
        bus(1'h0, ADCC_OFS_PIN_HIGH, 32'h0);
        chk("high", q, 32'h0000_003C);
        chk("oe_n", pad.oe_n, 16'h3CA5);
        chk("out", pad.out, 16'hC35A);
        chk("pullup", pad.pullup_en, 16'hC35A);
        chk("in_buf", pad.in_buf_en, 16'hC35A);
        chk("port_read", prd, 16'hC35A);
    endtask
    task automatic t_clock();
        for (int s = 0; s < 2; s++)
            for (int d = 0; d < 4; d++)
                period(8'(d * 32 + s), (s + 1) << d);
        period(8'h02, 6);
        bus(1'h1, ADCC_OFS_CFG, 32'h0000_0003);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0003);
        stop <= 1'h1;
        repeat (8) @(posedge clk_i);
        chk("async_on", aclk, 1'h1);
        chk("async_runs", aen, 1'h1);
        stop <= 1'h0;
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_001F);
    endtask
    task automatic t_conv();
        conv(8'h08, 11'd1001, 8'h01, 8'hF5);
        conv(8'h00, 11'd1013, 8'h01, 8'h7F);
        bus(1'h1, ADCC_OFS_SC2, 32'h0000_0030);
        bus(1'h1, ADCC_OFS_CV_LOW, 32'h0000_0064);
        conv(8'h00, 11'd1013, 8'h01, 8'h1B);
    endtask
    task automatic t_hw();
        bus(1'h1, ADCC_OFS_SC2, 32'h0000_0040);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0043);
        repeat (9) @(posedge clk_i);
        chk("no_sw_start", aen, 1'h0);
        hw <= 1'h1;
        wait_hi(aen);
        chk("hw_start", aen, 1'h1);
        hw <= 1'h0;
        repeat (3) @(posedge clk_i);
        hw <= 1'h1;
        wait_hi(irq);
        bus(1'h0, ADCC_OFS_RES_LOW, 32'h0);
        repeat (30) @(posedge clk_i);
        chk("edge_ignored", aen, 1'h0);
        hw <= 1'h0;
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0063);
        hw <= 1'h1;
        wait_hi(irq);
        bus(1'h0, ADCC_OFS_RES_LOW, 32'h0);
        hw <= 1'h0;
        repeat (2) @(posedge clk_i);
        hw <= 1'h1;
        wait_hi(irq);
        chk("hw_series", irq, 1'h1);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_001F);
        hw <= 1'h0;
    endtask
    task automatic t_cont();
        bus(1'h1, ADCC_OFS_SC2, 32'h0);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_0063);
        wait_hi(irq);
        bus(1'h0, ADCC_OFS_RES_LOW, 32'h0);
        chk("cleared", irq, 1'h0);
        wait_hi(irq);
        chk("sw_series", irq, 1'h1);
        bus(1'h1, ADCC_OFS_SC1, 32'h0000_001F);
        chk("aborted", aen, 1'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence: reset for three cycles, then every scenario
    initial begin
        rst_i = 1'h1;
        apb = '0;
        {hw, stop, vin} = '0;
        drv = 16'hFFFF;
        num_errors = 0;
        n_tests = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_pins();
        t_clock();
        t_conv();
        t_hw();
        t_cont();
        report_and_stop();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
endmodule
bind adcc_ctrl adcc_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_o(sample_o), .analog_enable_o(analog_enable_o),
    .irq_o(irq_o), .channel_o(channel_o), .pad_o(pad_o),
    .port_read_o(port_read_o));
